// File: serdes_defines.svh
`ifndef SERDES_DEFINES_SVH
`define SERDES_DEFINES_SVH
// Operation
// [RULE_01] serial line stays undriven until the transmit PLL has locked to the input clock
// [RULE_02] once locked, transmitter sends data or sync patterns chosen by the sync requests
// [RULE_03] a sync pattern is six ones then six zeros
// [RULE_04] sync patterns continue until both sync requests are low
// [RULE_05] either sync request high for 5 input clocks makes input words ignored
// [RULE_06] input word latched on rising edge when edge select high, else falling edge
// [RULE_07] every word framed by a start bit of one and a stop bit of zero
// [RULE_08] each twelve-bit frame is shifted out serially, one bit per line bit time
// [RULE_09] the data source supplies the input clock between 30 and 80 MHz
// [RULE_10] line driven only with driver enable and sleep high; enable low floats it
// [RULE_11] the system supplies a local reference clock for the receive PLL
// [RULE_12] acquired indicator stays high while the receiver is still locking
// [RULE_13] receiver locks after edge transitions are seen, then drives acquired low
// [RULE_14] output word is valid only while acquired is low
// [RULE_15] output word timed to the recovered clock, edge chosen by output edge select
// [RULE_16] on loss of lock acquired goes high and outputs and recovered clock float
// [RULE_17] receiving system pulses a sync request on loss of lock
// [RULE_18] receiver can acquire lock from random data without sync patterns
// [RULE_19] sleep low stops the transmit PLL and floats the line
// [RULE_20] after sleep rises the transmitter needs 510 input clocks to initialise
// [RULE_21] receiver enable low floats word and recovered clock; acquired keeps working
// [RULE_22] frame order is start bit, data bits 0 to 9, stop bit
// [RULE_23] lock after repeated good framing every twelve bits, loss after repeated mismatches
`define SERDES_DATA_W        10
`define SERDES_FRAME_W       12
`define SERDES_FRAME_LAST    4'hb
`define SERDES_CLK_HALF      4'h6
`define SERDES_SYNC_PATTERN  12'h03f
`define SERDES_TX_INIT_CYC   10'h1fe
`define SERDES_TX_HOLD_CYC   4'hf
`define SERDES_SYNC_IGN_CYC  3'h5
`define SERDES_RX_PLL_CYC    8'h40
`define SERDES_LOCK_FRAMES   4'h8
`define SERDES_LOSS_FRAMES   4'h4
`endif

// File: serdes_pkg.sv
`include "serdes_defines.svh"
package serdes_pkg;
	// transmit control pins as one group
	typedef struct packed {
		logic sleep_n;
		logic line_driver_enable;
		logic sync_request_b;
		logic sync_request_a;
		logic in_edge_select;
	} tx_ctrl_t;
	// receiver parallel outputs
	typedef struct packed {
		logic [`SERDES_DATA_W-1:0] word;
		logic                      clock;
	} rx_par_t;
	typedef enum logic [1:0] {TX_OFF = 2'b00, TX_SYNC = 2'b01, TX_DATA = 2'b11} tx_state_t;
	typedef enum logic [1:0] {RX_INIT = 2'b00, RX_HUNT = 2'b01, RX_CHECK = 2'b11, RX_LOCKED = 2'b10} rx_state_t;
endpackage : serdes_pkg

// File: serdes_bit_sync.sv
module serdes_bit_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	// two-stage synchroniser, first stage read only by the second
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q        <= meta_reg;
	end
endmodule : serdes_bit_sync

// File: serdes_tx_capture.sv
`include "serdes_defines.svh"
module serdes_tx_capture
	import serdes_pkg::*;
(
	input  wire logic                      parallel_in_clock,
	input  wire logic                      srst,
	input  wire serdes_pkg::tx_ctrl_t      ctrl,
	input  wire logic [`SERDES_DATA_W-1:0] parallel_in_word,
	input  wire logic                      ack_tgl,
	output logic                           req_tgl,
	output logic      [`SERDES_DATA_W-1:0] hold_word,
	output logic                           pll_locked
);
	import serdes_pkg::*;

	logic     [6:0] s_q;
	logic           ack_s;
	logic           rst_l;
	tx_ctrl_t       c_s;
	logic     [9:0] init_cnt_reg;
	logic     [2:0] sync_cnt_reg;
	logic     [`SERDES_DATA_W-1:0] neg_word_reg;
	logic     [`SERDES_DATA_W-1:0] pick;

	// reset, control pins and ack toggle into the input clock domain
	serdes_bit_sync #(.W(7)) u_sync (
		.clk (parallel_in_clock),
		.d   ({srst, ack_tgl, ctrl}),
		.q   (s_q)
	);
	assign rst_l = s_q[6];
	assign ack_s = s_q[5];
	assign c_s   = s_q[4:0];

	// lock counter restarts whenever sleep is low
	always_ff @(posedge parallel_in_clock) begin
		if (rst_l || !c_s.sleep_n) begin // [RULE_19]
			init_cnt_reg <= 10'h000;
			pll_locked   <= 1'b0;
		end else if (init_cnt_reg == `SERDES_TX_INIT_CYC - 10'h001) begin
			pll_locked   <= 1'b1; // [RULE_20]
		end else begin
			init_cnt_reg <= init_cnt_reg + 10'h001;
		end
	end

	// counts input clocks with a sync request held, saturating
	always_ff @(posedge parallel_in_clock) begin
		if (rst_l || !(c_s.sync_request_a || c_s.sync_request_b))
			sync_cnt_reg <= 3'h0;
		else if (sync_cnt_reg != `SERDES_SYNC_IGN_CYC)
			sync_cnt_reg <= sync_cnt_reg + 3'h1;
	end

	// falling-edge copy of the input word
	always_ff @(negedge parallel_in_clock) begin
		neg_word_reg <= parallel_in_word;
	end
	assign pick = c_s.in_edge_select ? parallel_in_word : neg_word_reg; // [RULE_06]

	// hand a word over when the previous one has been acknowledged
	always_ff @(posedge parallel_in_clock) begin
		if (rst_l) begin
			req_tgl   <= 1'b0;
			hold_word <= 10'h000;
		end else if (pll_locked && sync_cnt_reg != `SERDES_SYNC_IGN_CYC && req_tgl == ack_s) begin // [RULE_05]
			hold_word <= pick;
			req_tgl   <= ~req_tgl;
		end
	end
endmodule : serdes_tx_capture

// File: embedded_clock_serdes_link.sv
`include "serdes_defines.svh"
module embedded_clock_serdes_link
	import serdes_pkg::*;
(
	input  wire logic                      ref_clk,
	input  wire logic                      srst,
	input  wire logic                      parallel_in_clock,
	input  wire logic [`SERDES_DATA_W-1:0] parallel_in_word,
	input  wire serdes_pkg::tx_ctrl_t      tx_ctrl,
	output logic                           serial_line_out,
	output logic                           serial_line_oe,
	input  wire logic                      serial_line_in,
	input  wire logic                      rx_output_enable,
	input  wire logic                      out_edge_select,
	output serdes_pkg::rx_par_t            rx_par,
	output logic                           rx_par_oe,
	output logic                           acquired_n
);
	import serdes_pkg::*;

	logic                      req_tgl;
	logic [`SERDES_DATA_W-1:0] hold_word;
	logic                      tx_pll_locked;
	logic [7:0]                pin_s;
	logic                      sync_any;
	logic                      den_s;
	logic                      sleep_s;
	logic                      locked_s;
	logic                      req_s;
	logic                      rx_bit;
	logic                      ren_s;
	logic                      oes_s;
	// declared ahead of the capture instance, which reads it
	logic                      ack_tgl_reg;
	logic [3:0]                tx_hold_reg;

	// input clock domain: word latch, sync hold count, lock count
	serdes_tx_capture u_capture (
		.parallel_in_clock (parallel_in_clock),
		.srst              (srst),
		.ctrl              (tx_ctrl),
		.parallel_in_word  (parallel_in_word),
		.ack_tgl           (ack_tgl_reg),
		.req_tgl           (req_tgl),
		.hold_word         (hold_word),
		.pll_locked        (tx_pll_locked)
	);

	// pins and crossing signals into the ref_clk domain
	serdes_bit_sync #(.W(8)) u_pin_sync (
		.clk (ref_clk),
		.d   ({tx_ctrl.sync_request_a, tx_ctrl.sync_request_b, tx_ctrl.line_driver_enable,
		       tx_ctrl.sleep_n, tx_pll_locked, req_tgl, rx_output_enable, out_edge_select}),
		.q   (pin_s)
	);
	assign sync_any = pin_s[7] | pin_s[6];
	assign den_s    = pin_s[5];
	assign sleep_s  = pin_s[4];
	assign locked_s = pin_s[3];
	assign req_s    = pin_s[2];
	assign ren_s    = pin_s[1];
	assign oes_s    = pin_s[0];

	serdes_bit_sync #(.W(1)) u_line_sync (
		.clk (ref_clk),
		.d   (serial_line_in),
		.q   (rx_bit)
	);

	// ---------------- transmitter ----------------
	logic [`SERDES_DATA_W-1:0] tx_word_reg;
	tx_state_t                 tx_state_reg;
	tx_state_t                 tx_state_next;
	logic [3:0]                tx_pos_reg;
	logic [`SERDES_FRAME_W-1:0] tx_shift_reg;
	logic [`SERDES_FRAME_W-1:0] tx_frame;

	// line held off after reset or wake-up until the lock flag from the input
	// clock domain has had time to drop; that flag lags by several link clocks
	always_ff @(posedge ref_clk) begin
		if (srst || !sleep_s)
			tx_hold_reg <= `SERDES_TX_HOLD_CYC;
		else if (tx_hold_reg != 4'h0)
			tx_hold_reg <= tx_hold_reg - 4'h1;
	end

	// take the handed-over word; the source holds it until acknowledged
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ack_tgl_reg <= 1'b0;
			tx_word_reg <= 10'h000;
		end else if (req_s != ack_tgl_reg) begin
			tx_word_reg <= hold_word;
			ack_tgl_reg <= ~ack_tgl_reg;
		end
	end

	// mode chosen at frame boundaries, off at once on lost lock or sleep
	always_comb begin
		tx_state_next = tx_state_reg;
		if (tx_hold_reg != 4'h0 || !locked_s || !sleep_s) // [RULE_01] [RULE_19] [RULE_20]
			tx_state_next = TX_OFF;
		else if (tx_state_reg == TX_OFF || tx_pos_reg == `SERDES_FRAME_LAST)
			tx_state_next = sync_any ? TX_SYNC : TX_DATA; // [RULE_02] [RULE_04]
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			tx_state_reg <= TX_OFF;
		else
			tx_state_reg <= tx_state_next;
	end

	// frame bit counter, held at zero while off
	always_ff @(posedge ref_clk) begin
		if (srst || tx_state_next == TX_OFF)
			tx_pos_reg <= 4'h0;
		else if (tx_state_reg == TX_OFF || tx_pos_reg == `SERDES_FRAME_LAST)
			tx_pos_reg <= 4'h0;
		else
			tx_pos_reg <= tx_pos_reg + 4'h1;
	end

	// frame contents, sent lsb first
	always_comb begin
		if (tx_state_next == TX_SYNC)
			tx_frame = `SERDES_SYNC_PATTERN; // [RULE_03]
		else
			tx_frame = {1'b0, tx_word_reg, 1'b1}; // [RULE_07] [RULE_22]
	end

	// shift register and line driver
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_shift_reg    <= 12'h000;
			serial_line_out <= 1'b0;
		end else if (tx_state_reg == TX_OFF || tx_pos_reg == `SERDES_FRAME_LAST) begin
			tx_shift_reg    <= tx_frame >> 1; // [RULE_08]
			serial_line_out <= tx_frame[0];
		end else begin
			tx_shift_reg    <= tx_shift_reg >> 1;
			serial_line_out <= tx_shift_reg[0];
		end
	end

	// driver enable follows lock, sleep and the enable pin
	always_ff @(posedge ref_clk) begin
		if (srst)
			serial_line_oe <= 1'b0;
		else
			serial_line_oe <= (tx_state_next != TX_OFF) && den_s; // [RULE_10]
	end

	// ---------------- receiver ----------------
	rx_state_t                  rx_state_reg;
	rx_state_t                  rx_state_next;
	logic [7:0]                 rx_pll_cnt_reg;
	logic                       rx_prev_reg;
	logic [3:0]                 rx_pos_reg;
	logic [`SERDES_FRAME_W-1:0] rx_shift_reg;
	logic [`SERDES_FRAME_W-1:0] rx_win;
	logic [3:0]                 good_cnt_reg;
	logic [3:0]                 bad_cnt_reg;
	logic                       frame_end;
	logic                       frame_good;

	// last twelve bits with the current one at the top
	assign rx_win     = {rx_bit, rx_shift_reg[`SERDES_FRAME_W-1:1]};
	assign frame_end  = rx_pos_reg == `SERDES_FRAME_LAST;
	assign frame_good = rx_win[0] & ~rx_win[`SERDES_FRAME_W-1]; // [RULE_23]

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_shift_reg <= 12'h000;
			rx_prev_reg  <= 1'b0;
		end else begin
			rx_shift_reg <= rx_win;
			rx_prev_reg  <= rx_bit;
		end
	end

	// reference lock time after reset
	always_ff @(posedge ref_clk) begin
		if (srst)
			rx_pll_cnt_reg <= 8'h00;
		else if (rx_state_reg == RX_INIT)
			rx_pll_cnt_reg <= rx_pll_cnt_reg + 8'h01; // [RULE_11]
	end

	// acquisition state machine
	always_comb begin
		rx_state_next = rx_state_reg;
		unique case (rx_state_reg)
			RX_INIT: begin
				if (rx_pll_cnt_reg == `SERDES_RX_PLL_CYC - 8'h01)
					rx_state_next = RX_HUNT;
			end
			RX_HUNT: begin
				if (rx_bit != rx_prev_reg)
					rx_state_next = RX_CHECK; // [RULE_13]
			end
			RX_CHECK: begin
				if (frame_end && frame_good && good_cnt_reg == `SERDES_LOCK_FRAMES - 4'h1)
					rx_state_next = RX_LOCKED; // [RULE_13] [RULE_18]
			end
			RX_LOCKED: begin
				if (frame_end && !frame_good && bad_cnt_reg == `SERDES_LOSS_FRAMES - 4'h1)
					rx_state_next = RX_HUNT; // [RULE_16]
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			rx_state_reg <= RX_INIT;
		else
			rx_state_reg <= rx_state_next;
	end

	// frame position; a bad frame while checking slips alignment by one bit
	always_ff @(posedge ref_clk) begin
		if (srst || rx_state_reg == RX_INIT || rx_state_reg == RX_HUNT)
			rx_pos_reg <= 4'h0;
		else if (frame_end && !frame_good && rx_state_reg == RX_CHECK)
			rx_pos_reg <= rx_pos_reg; // [RULE_23]
		else if (frame_end)
			rx_pos_reg <= 4'h0;
		else
			rx_pos_reg <= rx_pos_reg + 4'h1;
	end

	// consecutive good and bad frame counters
	always_ff @(posedge ref_clk) begin
		if (srst || rx_state_reg != RX_CHECK)
			good_cnt_reg <= 4'h0;
		else if (frame_end)
			good_cnt_reg <= frame_good ? good_cnt_reg + 4'h1 : 4'h0;
	end

	always_ff @(posedge ref_clk) begin
		if (srst || rx_state_reg != RX_LOCKED)
			bad_cnt_reg <= 4'h0;
		else if (frame_end)
			bad_cnt_reg <= frame_good ? 4'h0 : bad_cnt_reg + 4'h1;
	end

	// acquired indicator, independent of the output enable
	always_ff @(posedge ref_clk) begin
		if (srst)
			acquired_n <= 1'b1;
		else
			acquired_n <= rx_state_next != RX_LOCKED; // [RULE_12] [RULE_21]
	end

	// output word, updated at frame end, cleared when not locked
	always_ff @(posedge ref_clk) begin
		if (srst || rx_state_next != RX_LOCKED)
			rx_par.word <= 10'h000; // [RULE_14]
		else if (frame_end && frame_good)
			rx_par.word <= rx_win[`SERDES_DATA_W:1]; // [RULE_22]
	end

	// recovered clock: active edge lands mid-frame, away from word changes
	always_ff @(posedge ref_clk) begin
		if (srst)
			rx_par.clock <= 1'b0;
		else
			rx_par.clock <= (rx_pos_reg >= `SERDES_CLK_HALF) == oes_s; // [RULE_15]
	end

	// outputs float when unlocked or receiver disabled
	always_ff @(posedge ref_clk) begin
		if (srst)
			rx_par_oe <= 1'b0;
		else
			rx_par_oe <= ren_s && rx_state_next == RX_LOCKED; // [RULE_16] [RULE_21]
	end
endmodule : embedded_clock_serdes_link

// File: embedded_clock_serdes_link_asserts.sv
module embedded_clock_serdes_link_asserts
	import serdes_pkg::*;
(
	input wire logic                 ref_clk,
	input wire logic                 srst,
	input wire serdes_pkg::tx_ctrl_t tx_ctrl,
	input wire logic                 serial_line_out,
	input wire logic                 serial_line_oe,
	input wire logic                 rx_output_enable,
	input wire logic                 out_edge_select,
	input wire serdes_pkg::rx_par_t  rx_par,
	input wire logic                 rx_par_oe,
	input wire logic                 acquired_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] sync_cnt_reg;
	logic [7:0] up_cnt_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// cycles a sync request has been held
	always_ff @(posedge ref_clk) begin
		if (srst || !(tx_ctrl.sync_request_a || tx_ctrl.sync_request_b))
			sync_cnt_reg <= 6'h00;
		else if (sync_cnt_reg != 6'h3f)
			sync_cnt_reg <= sync_cnt_reg + 6'h01;
	end
	// cycles since reset release, saturating
	always_ff @(posedge ref_clk) begin
		if (srst)
			up_cnt_reg <= 8'h00;
		else if (up_cnt_reg != 8'hff)
			up_cnt_reg <= up_cnt_reg + 8'h01;
	end
	sequence sync_frame;
		serial_line_out[*6] ##1 !serial_line_out[*6];
	endsequence
	sequence sel_held;
		out_edge_select[*4];
	endsequence
	a_sleep_float: assert property ((!tx_ctrl.sleep_n)[*4] |-> !serial_line_oe)
		else $error("line driven while asleep");
	a_den_float: assert property ((!tx_ctrl.line_driver_enable)[*4] |-> !serial_line_oe)
		else $error("line driven with driver off");
	a_sync_shape: assert property (sync_cnt_reg >= 6'h18 && serial_line_oe && $rose(serial_line_out) |-> sync_frame)
		else $error("bad sync frame");
	a_unlocked_quiet: assert property (acquired_n |-> !rx_par_oe && rx_par.word == 10'h000)
		else $error("outputs live without lock");
	a_ren_float: assert property ((!rx_output_enable)[*4] |-> !rx_par_oe)
		else $error("outputs live with receiver disabled");
	a_lock_delay: assert property (!acquired_n |-> up_cnt_reg >= 8'h9c)
		else $error("lock declared too early");
	a_rclk_half: assert property ($rose(rx_par.clock) && !acquired_n
		|-> (rx_par.clock || acquired_n)[*6] ##1 (!rx_par.clock || acquired_n))
		else $error("recovered clock high phase wrong");
	a_word_edge: assert property (sel_held ##0 ($changed(rx_par.word) && !acquired_n && !$past(acquired_n))
		|-> rx_par.clock ##1 $fell(rx_par.clock))
		else $error("word changed off clock edge");
endmodule : embedded_clock_serdes_link_asserts

bind embedded_clock_serdes_link embedded_clock_serdes_link_asserts u_embedded_clock_serdes_link_asserts (
	.ref_clk(ref_clk), .srst(srst), .tx_ctrl(tx_ctrl), .serial_line_out(serial_line_out),
	.serial_line_oe(serial_line_oe), .rx_output_enable(rx_output_enable), .out_edge_select(out_edge_select),
	.rx_par(rx_par), .rx_par_oe(rx_par_oe), .acquired_n(acquired_n));

// File: serdes_far_end.sv
module serdes_far_end (
	input  wire logic ref_clk,
	input  wire logic serial_line_out,
	input  wire logic serial_line_oe,
	output logic      parallel_in_clock,
	output logic      serial_line_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] noise_reg;
	// source word clock, 15 ns period, offset from the bit clock
	initial begin
		parallel_in_clock = 1'b0;
		#1;
		forever #7.5 parallel_in_clock = ~parallel_in_clock;
	end
	// a released line carries noise, never a stale level
	initial noise_reg = 16'hace1;
	always @(posedge ref_clk)
		noise_reg <= {noise_reg[14:0], noise_reg[15] ^ noise_reg[13] ^ noise_reg[12] ^ noise_reg[10]};
	assign serial_line_in = serial_line_oe ? serial_line_out : noise_reg[0];
endmodule : serdes_far_end

// File: embedded_clock_serdes_link_test.sv
module embedded_clock_serdes_link_test;
	import serdes_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic                ref_clk = 1'b0;
	logic                srst;
	logic                parallel_in_clock;
	logic [9:0]          parallel_in_word;
	tx_ctrl_t            tx_ctrl;
	logic                serial_line_out;
	logic                serial_line_oe;
	logic                serial_line_in;
	logic                rx_output_enable;
	logic                out_edge_select;
	rx_par_t             rx_par;
	logic                rx_par_oe;
	logic                acquired_n;
	logic [31:0]         seed;
	logic [31:0]         w;
	int                  num_errors;
	int                  compares;
	// bit clock, also the receiver's local reference
	always #2.5 ref_clk = ~ref_clk;
	embedded_clock_serdes_link u_embedded_clock_serdes_link (
		.ref_clk(ref_clk), .srst(srst), .parallel_in_clock(parallel_in_clock),
		.parallel_in_word(parallel_in_word), .tx_ctrl(tx_ctrl), .serial_line_out(serial_line_out),
		.serial_line_oe(serial_line_oe), .serial_line_in(serial_line_in), .rx_output_enable(rx_output_enable),
		.out_edge_select(out_edge_select), .rx_par(rx_par), .rx_par_oe(rx_par_oe), .acquired_n(acquired_n));
	serdes_far_end u_serdes_far_end (
		.ref_clk(ref_clk), .serial_line_out(serial_line_out), .serial_line_oe(serial_line_oe),
		.parallel_in_clock(parallel_in_clock), .serial_line_in(serial_line_in));
	task print_verdict();
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	// bounded wait on line enable (sel 0) or lock flag (sel 1)
	task await(input int sel, input logic lvl, input int lim);
		int n;
		n = 0;
		while (((sel == 0) ? serial_line_oe : acquired_n) !== lvl && n < lim) begin
			tick(1);
			n++;
		end
		if (((sel == 0) ? serial_line_oe : acquired_n) !== lvl) begin
			num_errors++;
			$display("unexpected wait %0d: expected %b seen timeout", sel, lvl);
			print_verdict();
		end
	endtask : await
	// random word and capture edge
	task new_word();
		w = $random(seed);
		parallel_in_word = w[9:0];
		tx_ctrl.in_edge_select = w[10];
	endtask : new_word
	initial begin
		seed = 32'hb366_421c;
		num_errors = 0;
		compares = 0;
		srst = 1'b1;
		parallel_in_word = 10'h000;
		tx_ctrl = 5'b11001;
		rx_output_enable = 1'b1;
		out_edge_select = 1'b1;
		tick(5);
		check("acquired_n", acquired_n, 1'b1);
		check("rx_par_oe", rx_par_oe, 1'b0);
		srst = 1'b0;
		tick(1000);
		check("oe init", serial_line_oe, 1'b0);
		await(0, 1'b1, 1000);
		// sync patterns bring the receiver into lock
		tx_ctrl.sync_request_a = 1'b1;
		await(1, 1'b0, 2000);
		check("acquired_n", acquired_n, 1'b0);
		for (int k = 1; k < 4; k++) begin
			{tx_ctrl.sync_request_b, tx_ctrl.sync_request_a} = k[1:0];
			new_word();
			tick(40);
			check("sync word", rx_par.word, 10'h01f);
			{tx_ctrl.sync_request_b, tx_ctrl.sync_request_a} = 2'b00;
			tick(60);
			check("word after sync", rx_par.word, w[9:0]);
		end
		// data words, corners first
		for (int i = 0; i < 8; i++) begin
			new_word();
			if (i < 2)
				parallel_in_word = i ? 10'h3ff : 10'h000;
			tick(60);
			check("word", rx_par.word, parallel_in_word);
			check("rx_par_oe", rx_par_oe, 1'b1);
		end
		rx_output_enable = 1'b0;
		tick(10);
		check("rx_par_oe", rx_par_oe, 1'b0);
		check("acquired_n", acquired_n, 1'b0);
		rx_output_enable = 1'b1;
		tick(10);
		check("rx_par_oe", rx_par_oe, 1'b1);
		// driver off loses lock, random data regains it
		tx_ctrl.line_driver_enable = 1'b0;
		tick(8);
		check("oe den", serial_line_oe, 1'b0);
		await(1, 1'b1, 2000);
		check("rx_par_oe", rx_par_oe, 1'b0);
		check("word unlocked", rx_par.word, 10'h000);
		// recovered clock polarity is switched only while unlocked
		out_edge_select = 1'b0;
		tx_ctrl.line_driver_enable = 1'b1;
		// a fresh word every frame, so no data bit pair keeps posing as framing
		for (int n = 0; n < 330 && acquired_n !== 1'b0; n++) begin
			new_word();
			tick(12);
		end
		await(1, 1'b0, 12);
		tick(60);
		check("word relock", rx_par.word, parallel_in_word);
		// sleep and the long wake-up
		tx_ctrl.sleep_n = 1'b0;
		tick(8);
		check("oe sleep", serial_line_oe, 1'b0);
		tx_ctrl.sleep_n = 1'b1;
		tick(1000);
		check("oe wake", serial_line_oe, 1'b0);
		await(0, 1'b1, 1000);
		check("oe awake", serial_line_oe, 1'b1);
		print_verdict();
	end
endmodule : embedded_clock_serdes_link_test
